// File: agng_pkg.sv
// constants, register map and shared helpers for the noise gate register bank
package agng_pkg;

  // register offsets on the control port
  localparam logic [7:0] ADDR_RIGHT_CTRL_C = 8'h1f;
  localparam logic [7:0] ADDR_LEFT_GAIN = 8'h20;
  localparam logic [7:0] ADDR_RIGHT_GAIN = 8'h21;
  localparam logic [7:0] ADDR_LEFT_DEB = 8'h22;
  localparam logic [7:0] ADDR_RIGHT_DEB = 8'h23;

  // reset values
  localparam logic [7:0] CTRL_C_RST = 8'h00;
  localparam logic [7:0] GAIN_RST = 8'h00;
  localparam logic [7:0] DEB_RST = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // field positions in the control register
  localparam int HYST_MSB = 7;
  localparam int HYST_LSB = 6;
  localparam int THR_MSB = 5;
  localparam int THR_LSB = 1;
  localparam int CLIP_BIT = 0;

  // field positions in the debounce registers
  localparam int NDEB_MSB = 7;
  localparam int NDEB_LSB = 3;
  localparam int SDEB_MSB = 2;
  localparam int SDEB_LSB = 0;

  // field encodings
  localparam logic [1:0] HYST_OFF = 2'h3;
  localparam logic [4:0] THR_DISABLED = 5'h00;
  localparam logic [6:0] THR_BASE_DB = 7'h1c;
  localparam logic [6:0] GAIN_MAX_CODE = 7'h77;
  localparam logic [4:0] DEB_LINEAR_LAST = 5'h07;
  localparam logic [11:0] DEB_LONG_TICKS = 12'h080;

  // timing: the debounce tick is half a millisecond
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEB_UNIT_US = 500;
  localparam int DEB_UNIT_CYC = DEB_UNIT_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic {
    AGNG_SIGNAL,
    AGNG_NOISE
  } agng_gate_e;

  // debounce code to a count of half-millisecond ticks
  function automatic logic [11:0] deb_ticks(input logic [4:0] code);
    logic [11:0] t;
    t = 12'h000;
    if (code == 5'h00) begin
      t = 12'h000;
    end else if (code <= DEB_LINEAR_LAST) begin
      t = 12'h001 << (code - 5'h01);
    end else begin
      t = 12'(DEB_LONG_TICKS * {7'h00, 5'(code - DEB_LINEAR_LAST)});
    end
    return t;
  endfunction

  // threshold code to attenuation below full scale in dB, zero = off
  function automatic logic [6:0] thr_db(input logic [4:0] code);
    logic [6:0] d;
    d = 7'h00;
    if (code != THR_DISABLED) begin
      d = 7'(THR_BASE_DB + {1'b0, code, 1'b0});
    end
    return d;
  endfunction

  // hysteresis code to dB, zero = off
  function automatic logic [1:0] hyst_db(input logic [1:0] code);
    logic [1:0] d;
    d = 2'h0;
    if (code != HYST_OFF) begin
      d = 2'(code + 2'h1);
    end
    return d;
  endfunction

endpackage

// File: agng_gate.sv
// one channel of noise/signal detection with debounce
`timescale 1ns/10ps
module agng_gate
  import agng_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_tick,
  input wire logic i_active,
  input wire logic [6:0] i_thr_db,
  input wire logic [1:0] i_hyst_db,
  input wire logic [6:0] i_power_atten_db,
  input wire logic [4:0] i_noise_code,
  input wire logic [2:0] i_signal_code,
  output logic o_noise
);

  agng_gate_e state_reg;
  agng_gate_e state_next;
  logic [11:0] cnt_reg;
  logic [11:0] cnt_next;
  logic change;
  logic [11:0] target;

  // detection and debounce; while active, the state only flips after the condition
  // has held through the programmed number of debounce ticks
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    change = 1'b0;
    target = 12'h000;
    case (state_reg)
      AGNG_SIGNAL: begin
        change = i_power_atten_db > i_thr_db;
        target = deb_ticks(i_noise_code);
      end
      AGNG_NOISE: begin
        // leave noise only once power clears threshold plus hysteresis
        change = ({1'b0, i_power_atten_db} + {6'h00, i_hyst_db}) <
                 {1'b0, i_thr_db};
        target = deb_ticks({2'h0, i_signal_code});
      end
      default: begin
        change = 1'b0;
        target = 12'h000;
      end
    endcase
    if (!i_active) begin
      state_next = AGNG_SIGNAL;
      cnt_next = 12'h000;
    end else if (change) begin
      if (cnt_reg >= target) begin
        state_next = (state_reg == AGNG_SIGNAL) ? AGNG_NOISE : AGNG_SIGNAL;
        cnt_next = 12'h000;
      end else if (i_tick) begin
        cnt_next = cnt_reg + 12'h001;
      end
    end else begin
      cnt_next = 12'h000; // condition broke, restart the interval
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      state_reg <= AGNG_SIGNAL;
      cnt_reg <= 12'h000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  assign o_noise = (state_reg == AGNG_NOISE);

endmodule

// File: agng_regs.sv
// agc noise gate register bank: right control c, gain reports, debounce
// Contract
// - right hysteresis bits 7:6 give 1, 2, 3 dB; code 11 turns it off
// - right threshold code zero disables noise and silence detection
// - right threshold codes 1..31 give -30 dB down to -90 dB in 2 dB steps
// - right control bit 0 enables clip stepping
// - read-only left applied gain, two's complement half-dB, reset zero
// - read-only right applied gain with the same encoding
// - left noise debounce codes 0..7 give 0 to 32 ms
// - noise debounce codes 8 and up give 64 ms times (code minus 7)
// - left signal debounce codes 0..7 give 0 to 32 ms
// - right noise debounce uses the same five-bit mapping
// - right signal debounce uses the same three-bit mapping
// - listed times hold only with double rate audio off
// - configuration fields and gain reports reset to zero
// - each channel's enable bit turns its gain loop on
// - detection status reads 1 while power is below the threshold
// - saturation reads 1 while applied gain equals the maximum gain
`timescale 1ns/10ps
module agng_regs
  import agng_pkg::*;
#(
  parameter int P_DEB_UNIT_CYC = DEB_UNIT_CYC
)
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr_en,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd_en,
  input wire logic i_double_rate_audio,
  input wire logic i_left_agc_en,
  input wire logic i_right_agc_en,
  input wire logic [4:0] i_left_noise_thr,
  input wire logic [1:0] i_left_hyst,
  input wire logic [6:0] i_left_max_gain,
  input wire logic [6:0] i_right_max_gain,
  input wire logic [7:0] i_left_gain,
  input wire logic [7:0] i_right_gain,
  input wire logic [6:0] i_left_power_atten_db,
  input wire logic [6:0] i_right_power_atten_db,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rd_valid,
  output logic o_left_loop_active,
  output logic o_right_loop_active,
  output logic [6:0] o_right_noise_thr_db,
  output logic [1:0] o_right_hyst_db,
  output logic o_right_clip_step_en,
  output logic o_left_noise_det,
  output logic o_right_noise_det,
  output logic o_left_sat,
  output logic o_right_sat
);

  // last prescaler count for normal rate and for double rate audio
  localparam logic [16:0] UNIT_LAST = 17'(P_DEB_UNIT_CYC - 1);
  localparam logic [16:0] UNIT_LAST_DRA = 17'(P_DEB_UNIT_CYC / 2 - 1);

  // software-visible registers
  logic [7:0] ctrl_c_reg;
  logic [7:0] ctrl_c_next;
  logic [7:0] left_deb_reg;
  logic [7:0] left_deb_next;
  logic [7:0] right_deb_reg;
  logic [7:0] right_deb_next;
  logic [7:0] left_gain_reg;
  logic [7:0] right_gain_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic [7:0] left_gain_next;
  logic [7:0] right_gain_next;

  // tick prescaler
  logic [16:0] pre_cnt_reg;
  logic [16:0] pre_cnt_next;
  logic tick_reg;
  logic tick_next;

  // registered outputs
  logic left_active_reg;
  logic right_active_reg;
  logic [6:0] right_thr_reg;
  logic [1:0] right_hyst_reg;
  logic clip_reg;
  logic left_sat_reg;
  logic right_sat_reg;
  logic left_sat_next;
  logic right_sat_next;
  logic left_active_next;
  logic right_active_next;
  logic [6:0] right_thr_next;
  logic [1:0] right_hyst_next;
  logic clip_next;

  // detector status, raw from the channel gates and registered here
  logic left_noise_raw;
  logic right_noise_raw;
  logic left_det_reg;
  logic left_det_next;
  logic right_det_reg;
  logic right_det_next;

  // channel configuration decoded from the fields
  logic [6:0] left_thr_db;
  logic [6:0] right_thr_db;
  logic left_gate_on;
  logic right_gate_on;

  // saturation: the loop clamps maximum gain codes above 59.5 dB
  function automatic logic at_max(input logic [7:0] gain,
                                  input logic [6:0] max_code);
    logic [6:0] lim;
    lim = (max_code > GAIN_MAX_CODE) ? GAIN_MAX_CODE : max_code;
    return (gain[7] == 1'b0) && (gain[6:0] == lim);
  endfunction

  // register writes; the gain reports ignore writes, and writes to
  // unmapped places are dropped without any error indication
  // the gain reports are refreshed from the loop every cycle
  always_comb begin
    left_gain_next = i_left_gain;
    right_gain_next = i_right_gain;
    ctrl_c_next = ctrl_c_reg;
    left_deb_next = left_deb_reg;
    right_deb_next = right_deb_reg;
    if (i_reg_wr_en) begin
      case (i_reg_addr)
        ADDR_RIGHT_CTRL_C: ctrl_c_next = i_reg_wdata;
        ADDR_LEFT_DEB: left_deb_next = i_reg_wdata;
        ADDR_RIGHT_DEB: right_deb_next = i_reg_wdata;
        default: ctrl_c_next = ctrl_c_reg;
      endcase
    end
  end

  // read mux; data arrives one cycle after the strobe
  // a read in the same cycle as a write returns the old value
  always_comb begin
    rd_valid_next = i_reg_rd_en;
    rdata_next = rdata_reg;
    if (i_reg_rd_en) begin
      case (i_reg_addr)
        ADDR_RIGHT_CTRL_C: rdata_next = ctrl_c_reg;
        ADDR_LEFT_GAIN: rdata_next = left_gain_reg;
        ADDR_RIGHT_GAIN: rdata_next = right_gain_reg;
        ADDR_LEFT_DEB: rdata_next = left_deb_reg;
        ADDR_RIGHT_DEB: rdata_next = right_deb_reg;
        default: rdata_next = RDATA_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      ctrl_c_reg <= CTRL_C_RST;
      left_deb_reg <= DEB_RST;
      right_deb_reg <= DEB_RST;
      left_gain_reg <= GAIN_RST;
      right_gain_reg <= GAIN_RST;
      rdata_reg <= RDATA_UNMAPPED;
      rd_valid_reg <= 1'b0;
    end else begin
      ctrl_c_reg <= ctrl_c_next;
      left_deb_reg <= left_deb_next;
      right_deb_reg <= right_deb_next;
      left_gain_reg <= left_gain_next;
      right_gain_reg <= right_gain_next;
      rdata_reg <= rdata_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  // half-millisecond tick; double rate audio halves the period, so the
  // encoded debounce times no longer hold in that mode
  always_comb begin
    tick_next = 1'b0;
    pre_cnt_next = pre_cnt_reg + 17'h0_0001;
    if (pre_cnt_reg >= (i_double_rate_audio ? UNIT_LAST_DRA
                                            : UNIT_LAST)) begin
      pre_cnt_next = 17'h0_0000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      pre_cnt_reg <= 17'h0_0000;
      tick_reg <= 1'b0;
    end else begin
      pre_cnt_reg <= pre_cnt_next;
      tick_reg <= tick_next;
    end
  end

  // threshold decode; a zero code keeps the detector idle
  // the left control fields arrive as inputs from outside this bank
  assign left_thr_db = thr_db(i_left_noise_thr);
  assign right_thr_db = thr_db(ctrl_c_reg[THR_MSB:THR_LSB]);
  assign left_gate_on = i_left_agc_en && (left_thr_db != 7'h00);
  assign right_gate_on = i_right_agc_en &&
                         (right_thr_db != 7'h00);

  // loop enables and decoded configuration for the right gain loop; the loop sees it one
  // cycle after a write, which keeps the decode off its timing path
  always_comb begin
    left_active_next = i_left_agc_en;
    right_active_next = i_right_agc_en;
    right_thr_next = right_thr_db;
    right_hyst_next = hyst_db(ctrl_c_reg[HYST_MSB:HYST_LSB]);
    clip_next = ctrl_c_reg[CLIP_BIT];
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      left_active_reg <= 1'b0;
      right_active_reg <= 1'b0;
      right_thr_reg <= 7'h00;
      right_hyst_reg <= 2'h0;
      clip_reg <= 1'b0;
    end else begin
      left_active_reg <= left_active_next;
      right_active_reg <= right_active_next;
      right_thr_reg <= right_thr_next;
      right_hyst_reg <= right_hyst_next;
      clip_reg <= clip_next;
    end
  end

  // status copies: saturation follows the captured applied gain, and the
  // detector state is masked by its enable so that turning the loop or
  // the threshold off clears the status at the very next edge
  always_comb begin
    left_sat_next = at_max(left_gain_reg, i_left_max_gain);
    right_sat_next = at_max(right_gain_reg, i_right_max_gain);
    left_det_next = left_noise_raw && left_gate_on;
    right_det_next = right_noise_raw && right_gate_on;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      left_sat_reg <= 1'b0;
      right_sat_reg <= 1'b0;
      left_det_reg <= 1'b0;
      right_det_reg <= 1'b0;
    end else begin
      left_sat_reg <= left_sat_next;
      right_sat_reg <= right_sat_next;
      left_det_reg <= left_det_next;
      right_det_reg <= right_det_next;
    end
  end

  // left channel detector; threshold, hysteresis and enable come from
  // inputs because the left control register lives outside this bank
  agng_gate u_left_gate (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_tick(tick_reg),
    .i_active(left_gate_on),
    .i_thr_db(left_thr_db),
    .i_hyst_db(hyst_db(i_left_hyst)),
    .i_power_atten_db(i_left_power_atten_db),
    .i_noise_code(left_deb_reg[NDEB_MSB:NDEB_LSB]),
    .i_signal_code(left_deb_reg[SDEB_MSB:SDEB_LSB]),
    .o_noise(left_noise_raw)
  );

  // right channel detector, configured from control register c and the
  // right debounce register held in this bank
  agng_gate u_right_gate (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_tick(tick_reg),
    .i_active(right_gate_on),
    .i_thr_db(right_thr_db),
    .i_hyst_db(hyst_db(ctrl_c_reg[HYST_MSB:HYST_LSB])),
    .i_power_atten_db(i_right_power_atten_db),
    .i_noise_code(right_deb_reg[NDEB_MSB:NDEB_LSB]),
    .i_signal_code(right_deb_reg[SDEB_MSB:SDEB_LSB]),
    .o_noise(right_noise_raw)
  );

  assign o_reg_rdata = rdata_reg;
  assign o_reg_rd_valid = rd_valid_reg;
  assign o_left_loop_active = left_active_reg;
  assign o_right_loop_active = right_active_reg;
  assign o_right_noise_thr_db = right_thr_reg;
  assign o_right_hyst_db = right_hyst_reg;
  assign o_right_clip_step_en = clip_reg;
  assign o_left_noise_det = left_det_reg;
  assign o_right_noise_det = right_det_reg;
  assign o_left_sat = left_sat_reg;
  assign o_right_sat = right_sat_reg;

endmodule

// File: agng_regs_chk.sv
// concurrent checks on the noise gate register bank ports
`timescale 1ns/10ps
module agng_regs_chk
  import agng_pkg::*;
#(
  parameter int P_DEB_UNIT_CYC = 8
)
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr_en,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd_en,
  input wire logic i_right_agc_en,
  input wire logic [6:0] i_right_max_gain,
  input wire logic [7:0] i_right_gain,
  input wire logic [6:0] i_right_power_atten_db,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rd_valid,
  input wire logic [6:0] o_right_noise_thr_db,
  input wire logic [1:0] o_right_hyst_db,
  input wire logic o_right_clip_step_en,
  input wire logic o_right_noise_det,
  input wire logic o_right_sat
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  logic ctl_wr;
  // a write into the right control register
  assign ctl_wr = i_reg_wr_en && (i_reg_addr == ADDR_RIGHT_CTRL_C);

  a_rd_answer: assert property (i_reg_rd_en |=> o_reg_rd_valid)
    else $error("read answer missing");
  a_rd_unmapped: assert property (
    i_reg_rd_en && (i_reg_addr < 8'h1f || i_reg_addr > 8'h23)
    |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
  // decoded fields show one edge after the write edge
  a_thr_decode: assert property (ctl_wr ##1 !ctl_wr |=>
    o_right_noise_thr_db == ((($past(i_reg_wdata, 2) & 8'h3e) == 8'h00)
    ? 7'h00 : 7'h1c + 7'($past(i_reg_wdata, 2) & 8'h3e)))
    else $error("threshold decode wrong");
  a_hyst_decode: assert property (ctl_wr ##1 !ctl_wr |=>
    o_right_hyst_db == ((($past(i_reg_wdata, 2) >> 6) == 8'h03) ? 2'h0
    : 2'($past(i_reg_wdata, 2) >> 6) + 2'h1))
    else $error("hysteresis decode wrong");
  a_clip_decode: assert property (ctl_wr ##1 !ctl_wr |=>
    o_right_clip_step_en == $past(i_reg_wdata[0], 2))
    else $error("clip stepping bit wrong");
  a_agc_off: assert property (
    !i_right_agc_en [*3] |-> !o_right_noise_det)
    else $error("detection while loop off");
  a_thr_off: assert property (
    (o_right_noise_thr_db == 7'h00) [*3] |-> !o_right_noise_det)
    else $error("detection while threshold off");
  a_noise_entry: assert property ($rose(o_right_noise_det) |->
    $past(i_right_power_atten_db) > $past(o_right_noise_thr_db))
    else $error("noise flagged above threshold");
  a_sat_set: assert property (
    (i_right_gain == {1'b0, i_right_max_gain} && i_right_max_gain <= 7'h77)
    [*4] |-> o_right_sat) else $error("saturation missed");
  // reset is synchronous, so outputs clear one edge later
  a_reset_clear: assert property (disable iff (1'b0)
    !i_rst_b |=> !o_reg_rd_valid && !o_right_clip_step_en
    && o_right_noise_thr_db == 7'h00 && !o_right_noise_det)
    else $error("reset did not clear outputs");

  c_ctl_write: cover property (ctl_wr);
  c_noise_on: cover property ($rose(o_right_noise_det));
  c_noise_off: cover property ($fell(o_right_noise_det));
  c_sat: cover property (o_right_sat);
endmodule

bind agng_regs agng_regs_chk #(.P_DEB_UNIT_CYC(P_DEB_UNIT_CYC))
  agng_regs_chk_i (
  .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr),
  .i_reg_wr_en(i_reg_wr_en), .i_reg_wdata(i_reg_wdata),
  .i_reg_rd_en(i_reg_rd_en), .i_right_agc_en(i_right_agc_en),
  .i_right_max_gain(i_right_max_gain), .i_right_gain(i_right_gain),
  .i_right_power_atten_db(i_right_power_atten_db),
  .o_reg_rdata(o_reg_rdata), .o_reg_rd_valid(o_reg_rd_valid),
  .o_right_noise_thr_db(o_right_noise_thr_db),
  .o_right_hyst_db(o_right_hyst_db),
  .o_right_clip_step_en(o_right_clip_step_en),
  .o_right_noise_det(o_right_noise_det), .o_right_sat(o_right_sat));

// File: testbench.sv
// self-checking bench for the noise gate register bank
`timescale 1ns/10ps
module testbench;
  import agng_pkg::*;
  localparam int U = 8;
  logic i_mclk = 1'b0, i_rst_b = 1'b0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00;
  logic i_reg_wr_en = 1'b0, i_reg_rd_en = 1'b0, i_double_rate_audio = 1'b0;
  logic i_left_agc_en = 1'b1, i_right_agc_en = 1'b1;
  logic [4:0] i_left_noise_thr = 5'h01;
  logic [1:0] i_left_hyst = 2'h3;
  logic [6:0] i_left_max_gain = 7'h10, i_right_max_gain = 7'h10;
  logic [7:0] i_left_gain = 8'h00, i_right_gain = 8'h00;
  logic [6:0] i_left_power_atten_db = 7'h0a, i_right_power_atten_db = 7'h0a;
  logic [7:0] o_reg_rdata;
  logic [6:0] o_right_noise_thr_db;
  logic [1:0] o_right_hyst_db;
  logic o_reg_rd_valid, o_left_loop_active, o_right_loop_active;
  logic o_right_clip_step_en, o_left_noise_det, o_right_noise_det;
  logic o_left_sat, o_right_sat;
  int n_fail = 0, checked = 0, cyc = 0;
  logic [4:0] thr_tab [4] = '{5'h00, 5'h01, 5'h02, 5'h1f};

  agng_regs #(.P_DEB_UNIT_CYC(U)) agng_regs_i (.*);

  // free-running clock and a cycle ceiling against hangs
  always #5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr_en <= 1'b1;
    @(posedge i_mclk);
    i_reg_wr_en <= 1'b0;
  endtask

  // strobe one read and compare the answer a cycle later
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_reg_addr <= a;
    i_reg_rd_en <= 1'b1;
    @(posedge i_mclk);
    i_reg_rd_en <= 1'b0;
    #1;
    chk(o_reg_rd_valid, 8'h01);
    chk(o_reg_rdata, e);
  endtask

  // half-millisecond ticks for a debounce code
  function automatic int tk(input int c);
    return c == 0 ? 0 : (c <= 7 ? 1 << (c - 1) : 128 * (c - 7));
  endfunction

  // drive both levels and time how long each status takes to follow
  task automatic meas(input logic [6:0] lvl, input logic tgt,
                      input int tl, input int tr, input int u);
    int nl, nr;
    nl = -1;
    nr = -1;
    @(posedge i_mclk);
    i_left_power_atten_db <= lvl;
    i_right_power_atten_db <= lvl;
    for (int n = 0; n < 30000 && (nl < 0 || nr < 0); n++) begin
      @(posedge i_mclk);
      #1;
      if (nl < 0 && o_left_noise_det === tgt) nl = n;
      if (nr < 0 && o_right_noise_det === tgt) nr = n;
    end
    chk(8'(nl >= (tl - 1) * u && nl <= tl * u + 4), 8'h01);
    chk(8'(nr >= (tr - 1) * u && nr <= tr * u + 4), 8'h01);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    // every mapped place reads zero after reset, the unmapped one too
    for (int a = 8'h1f; a <= 8'h24; a++) begin
      rdchk(8'(a), 8'h00);
    end
    $display("test reset done");
    @(posedge i_mclk);
    i_left_gain <= 8'he8;
    i_right_gain <= 8'h77;
    wr(8'h1f, 8'ha5);
    wr(8'h22, 8'h5a);
    wr(8'h23, 8'hc3);
    wr(8'h20, 8'hff);
    wr(8'h21, 8'hff);
    rdchk(8'h1f, 8'ha5);
    rdchk(8'h22, 8'h5a);
    rdchk(8'h23, 8'hc3);
    rdchk(8'h20, 8'he8);
    rdchk(8'h21, 8'h77);
    $display("test access done");
    // every hysteresis code, threshold ends and off, clip on and off
    for (int i = 0; i < 4; i++) begin
      wr(8'h1f, {2'(i), thr_tab[i], i[0]});
      @(posedge i_mclk);
      #1;
      chk(o_right_hyst_db, (i == 3) ? 8'h00 : 8'(i + 1));
      chk(o_right_noise_thr_db, thr_tab[i] == 5'h00 ? 8'h00
          : 8'h1c + 8'(2 * thr_tab[i]));
      chk(o_right_clip_step_en, 8'(i[0]));
    end
    $display("test decode done");
    @(posedge i_mclk);
    i_left_gain <= 8'h10;
    i_right_gain <= 8'h10;
    repeat (4) @(posedge i_mclk);
    #1;
    chk(o_left_sat, 8'h01);
    chk(o_right_sat, 8'h01);
    chk(o_right_loop_active, 8'h01);
    @(posedge i_mclk);
    i_left_gain <= 8'h0f;
    i_right_gain <= 8'h0f;
    repeat (4) @(posedge i_mclk);
    #1;
    chk(o_left_sat, 8'h00);
    chk(o_right_sat, 8'h00);
    $display("test saturation done");
    // threshold 30 dB with hysteresis off; levels 40 and 10 dB down
    wr(8'h1f, 8'hc2);
    wr(8'h22, 8'h43);
    wr(8'h23, 8'h10);
    meas(7'd40, 1'b1, tk(8), tk(2), U);
    meas(7'd10, 1'b0, tk(3), tk(0), U);
    wr(8'h22, 8'h27);
    wr(8'h23, 8'hff);
    meas(7'd40, 1'b1, tk(4), tk(31), U);
    meas(7'd10, 1'b0, tk(7), tk(7), U);
    @(posedge i_mclk);
    i_double_rate_audio <= 1'b1;
    meas(7'd40, 1'b1, tk(4), tk(31), U / 2);
    $display("test debounce done");
    wr(8'h1f, 8'hc0);
    i_left_agc_en <= 1'b0;
    repeat (3) @(posedge i_mclk);
    #1;
    chk(o_right_noise_det, 8'h00);
    chk(o_left_noise_det, 8'h00);
    chk(o_left_loop_active, 8'h00);
    // right gate on again: zero debounce, 30 dB threshold, 3 dB hysteresis
    wr(8'h23, 8'h00);
    wr(8'h1f, 8'h82);
    repeat (3) @(posedge i_mclk);
    #1;
    chk(o_right_noise_det, 8'h01);
    chk(o_right_hyst_db, 8'h03);
    // 28 dB down stays inside the hysteresis band, 26 dB leaves it
    @(posedge i_mclk);
    i_right_power_atten_db <= 7'd28;
    repeat (4) @(posedge i_mclk);
    #1;
    chk(o_right_noise_det, 8'h01);
    @(posedge i_mclk);
    i_right_power_atten_db <= 7'd26;
    repeat (4) @(posedge i_mclk);
    #1;
    chk(o_right_noise_det, 8'h00);
    @(posedge i_mclk);
    i_right_power_atten_db <= 7'd40;
    repeat (4) @(posedge i_mclk);
    #1;
    chk(o_right_noise_det, 8'h01);
    @(posedge i_mclk);
    i_right_agc_en <= 1'b0;
    repeat (3) @(posedge i_mclk);
    #1;
    chk(o_right_noise_det, 8'h00);
    chk(o_right_loop_active, 8'h00);
    $display("test disable done");
    tally_and_finish();
  end
endmodule
